/* verilog/scbp_pkg.sv */
`default_nettype none
package scbp_pkg;
	// widths of the shared processor bus
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 1;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	// the bus addresses this many bytes with the lowest address bit included
	localparam int ADDR_SPACE_BYTES = 16777216;
	// strap decode
	localparam logic STRAP_NARROW = 1'b0;
	localparam logic STRAP_WIDE = 1'b1;
	// reset timing held by the outside world
	localparam int POR_HOLD_MS = 100;
	localparam int TOTAL_RST_MIN_CLKS = 10;
	// clock rate
	localparam int CLK_MHZ = 125;
	localparam int CLK_PERIOD_NS = 8;
	// width of the reset pulse driven after a core reset instruction
	localparam int INSTR_RST_CLKS = 16;
	localparam int INSTR_CNT_W = 8;
	// pin synchroniser depth
	localparam int SYNC_STAGES = 2;
	// default number of freezable peripherals
	localparam int FREEZE_UNITS = 8;
	typedef enum logic [1:0] {
		SCBP_RUN,
		SCBP_TOTAL,
		SCBP_INSTR
	} scbp_rst_state_t;
endpackage : scbp_pkg
`default_nettype wire

/* verilog/scbp_sys_ctrl.sv */
//Contract
//- reset and halt both asserted start a total reset of every unit.
//- no reset path ever clears the on-chip system RAM.
//- core reset instruction drives reset pin, resets CP and most of SIB, not core.
//- external halt stops the internal bus master after its current cycle.
//- core stopped by double fault drives the halt pin.
//- bus fault driven on watchdog timeout, address conflict or write-protect violation.
//- bus width strap low gives 8-bit bus, high gives 16-bit bus.
//- core disable strap taken during total reset keeps the core inactive.
//- freeze input suspends the selected peripherals.
//- address lines 23..1 driven when core or DMA masters the bus, else inputs.
//- 16-bit accesses carry byte 0 on data lines 15..8.
//- 8-bit bus moves all data on data lines 7..0, upper byte unused.
//- internal accesses shown on pins, external accesses shown internally.
//- external master hitting a programmed range gets chip select and acknowledge.
//- one clock runs all units, is driven out, and times the bus.
`timescale 1ns/1ps
`default_nettype none
module scbp_sys_ctrl
	import scbp_pkg::*;
#(
	parameter int FREEZE_N = FREEZE_UNITS,
	parameter int INSTR_RST_LEN = INSTR_RST_CLKS
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	output logic clock_output_pin_o,
	// open-drain system control pins and freeze input active low on the wire; both straps active high
	input wire logic reset_pin_n_i,
	output logic reset_pin_n_o,
	output logic reset_pin_oe_o,
	input wire logic halt_pin_n_i,
	output logic halt_pin_n_o,
	output logic halt_pin_oe_o,
	input wire logic bus_fault_line_n_i,
	output logic bus_fault_line_n_o,
	output logic bus_fault_line_oe_o,
	input wire logic bus_width_strap_i,
	input wire logic core_disable_strap_i,
	input wire logic freeze_input_n_i,
	// internal events
	input wire logic core_reset_instr_i,
	input wire logic double_fault_i,
	input wire logic watchdog_timeout_i,
	input wire logic cs_addr_conflict_i,
	input wire logic cs_write_protect_i,
	input wire logic cs_range_hit_i,
	input wire logic bus_cycle_active_i,
	input wire logic int_master_i,
	input wire logic [FREEZE_N-1:0] freeze_select_i,
	// internal bus side
	input wire logic [ADDR_HI:ADDR_LO] int_addr_i,
	input wire logic int_a0_i,
	input wire logic int_write_i,
	input wire logic [DATA_W-1:0] int_wdata_i,
	output logic [DATA_W-1:0] int_rdata_o,
	output logic [ADDR_HI:ADDR_LO] ext_addr_seen_o,
	// address and data pins
	input wire logic [ADDR_HI:ADDR_LO] addr_pin_i,
	output logic [ADDR_HI:ADDR_LO] addr_pin_o,
	output logic addr_pin_oe_o,
	input wire logic [DATA_W-1:0] data_pin_i,
	output logic [DATA_W-1:0] data_pin_o,
	output logic [1:0] data_lane_oe_o,
	// unit resets and status
	output logic core_reset_o,
	output logic cp_reset_o,
	output logic sib_reset_o,
	output logic sib_cfg_reset_o,
	output logic core_enable_o,
	output logic wide_bus_o,
	output logic bus_stop_o,
	output logic bus_fault_o,
	output logic ext_chip_sel_o,
	output logic ext_dtack_o,
	output logic [FREEZE_N-1:0] freeze_unit_o
);

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_STAGES-1:0] rst_sync_q;
	logic [SYNC_STAGES-1:0] halt_sync_q;
	logic [SYNC_STAGES-1:0] freeze_sync_q;
	logic [SYNC_STAGES-1:0] fault_sync_q;
	logic [SYNC_STAGES-1:0] width_sync_q;
	logic [SYNC_STAGES-1:0] dis_sync_q;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_sync_q <= '0;
			halt_sync_q <= '0;
			freeze_sync_q <= '0;
			fault_sync_q <= '0;
			width_sync_q <= '0;
			dis_sync_q <= '0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], ~reset_pin_n_i};
			halt_sync_q <= {halt_sync_q[0], ~halt_pin_n_i};
			freeze_sync_q <= {freeze_sync_q[0], ~freeze_input_n_i};
			fault_sync_q <= {fault_sync_q[0], ~bus_fault_line_n_i};
			width_sync_q <= {width_sync_q[0], bus_width_strap_i};
			dis_sync_q <= {dis_sync_q[0], core_disable_strap_i};
		end
	end

	wire rst_seen = rst_sync_q[SYNC_STAGES-1];
	wire halt_seen = halt_sync_q[SYNC_STAGES-1];
	wire freeze_seen = freeze_sync_q[SYNC_STAGES-1];

	////////////////////////////////////////////////////////////////
	// reset sequencing
	scbp_rst_state_t state_q;
	scbp_rst_state_t state_d;
	logic [INSTR_CNT_W-1:0] cnt_q;
	logic [INSTR_CNT_W-1:0] cnt_d;
	logic rst_drive_q;
	logic halt_drive_q;
	logic fault_drive_q;
	logic [SYNC_STAGES-1:0] rst_echo_q;
	logic [SYNC_STAGES-1:0] halt_echo_q;
	logic width_q;
	logic core_dis_q;

	// own drive echoes back through the synchroniser for two more cycles; only a foreign drive counts
	wire ext_reset = rst_seen & ~rst_drive_q & ~(|rst_echo_q);
	wire ext_halt = halt_seen & ~halt_drive_q & ~(|halt_echo_q);
	wire total_req = ext_reset & halt_seen;
	wire instr_done = (cnt_q == INSTR_CNT_W'(INSTR_RST_LEN - 1));

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			SCBP_RUN: begin
				cnt_d = '0;
				if (total_req) begin
					state_d = SCBP_TOTAL;
				end else if (core_reset_instr_i) begin
					state_d = SCBP_INSTR;
				end
			end
			SCBP_TOTAL: begin
				// holds as long as both pins stay low; the hold time is the outside world's job
				if (!total_req) begin
					state_d = SCBP_RUN;
				end
			end
			SCBP_INSTR: begin
				cnt_d = cnt_q + INSTR_CNT_W'(1);
				if (instr_done) begin
					state_d = SCBP_RUN;
				end
			end
			default: begin
				state_d = SCBP_RUN;
			end
		endcase
	end

	wire in_total = (state_q == SCBP_TOTAL);
	wire in_instr = (state_q == SCBP_INSTR);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= SCBP_RUN;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// straps follow the pins only while a total reset is in progress
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			width_q <= STRAP_WIDE;
			core_dis_q <= 1'b0;
		end else if (in_total) begin
			width_q <= width_sync_q[SYNC_STAGES-1];
			core_dis_q <= dis_sync_q[SYNC_STAGES-1];
		end
	end

	// the system RAM has no clear input; none of these resets reaches it
	assign core_reset_o = rst_i | in_total;
	assign cp_reset_o = rst_i | in_total | in_instr;
	assign sib_reset_o = rst_i | in_total | in_instr;
	assign sib_cfg_reset_o = rst_i | in_total;
	assign core_enable_o = ~core_dis_q & ~core_reset_o;
	assign wide_bus_o = (width_q == STRAP_WIDE);

	////////////////////////////////////////////////////////////////
	// open-drain drivers, halt and bus fault
	logic stop_q;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_drive_q <= 1'b0;
			halt_drive_q <= 1'b0;
			fault_drive_q <= 1'b0;
			rst_echo_q <= '0;
			halt_echo_q <= '0;
			stop_q <= 1'b0;
		end else begin
			rst_drive_q <= state_d == SCBP_INSTR;
			halt_drive_q <= double_fault_i & ~in_total;
			fault_drive_q <= watchdog_timeout_i | cs_addr_conflict_i | cs_write_protect_i;
			rst_echo_q <= {rst_echo_q[0], rst_drive_q};
			halt_echo_q <= {halt_echo_q[0], halt_drive_q};
			// stop only once the running cycle has ended
			if (!ext_halt) begin
				stop_q <= 1'b0;
			end else if (!bus_cycle_active_i) begin
				stop_q <= 1'b1;
			end
		end
	end

	assign reset_pin_n_o = 1'b0;
	assign reset_pin_oe_o = rst_drive_q;
	assign halt_pin_n_o = 1'b0;
	assign halt_pin_oe_o = halt_drive_q;
	assign bus_fault_line_n_o = 1'b0;
	assign bus_fault_line_oe_o = fault_drive_q;
	assign bus_stop_o = stop_q;
	// external circuitry may pull the line too, so report the wire
	assign bus_fault_o = fault_sync_q[SYNC_STAGES-1] | fault_drive_q;

	////////////////////////////////////////////////////////////////
	// freeze
	genvar gi;
	generate
		for (gi = 0; gi < FREEZE_N; gi++) begin : g_freeze
			assign freeze_unit_o[gi] = freeze_seen & freeze_select_i[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// address and data pins
	logic [ADDR_HI:ADDR_LO] addr_out_q;
	logic [ADDR_HI:ADDR_LO] ext_addr_q;
	logic [DATA_W-1:0] dout_q;
	logic [1:0] lane_oe_q;
	logic [DATA_W-1:0] rdata_q;
	logic ext_cs_q;

	wire narrow = ~wide_bus_o;
	// narrow bus: the addressed byte always travels on the low lane
	wire [BYTE_W-1:0] narrow_byte = int_a0_i ? int_wdata_i[BYTE_W-1:0] : int_wdata_i[DATA_W-1:BYTE_W];
	wire [DATA_W-1:0] dout_d = narrow ? {{BYTE_W{1'b0}}, narrow_byte} : int_wdata_i;
	wire [BYTE_W-1:0] pin_lo = data_pin_i[BYTE_W-1:0];
	wire [DATA_W-1:0] rdata_d = narrow ? (int_a0_i ? {{BYTE_W{1'b0}}, pin_lo} : {pin_lo, {BYTE_W{1'b0}}})
		: data_pin_i;
	wire drive_data = int_master_i & int_write_i;
	wire ext_hit = ~int_master_i & cs_range_hit_i & bus_cycle_active_i;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_out_q <= '0;
			ext_addr_q <= '0;
			dout_q <= '0;
			lane_oe_q <= 2'h0;
			rdata_q <= '0;
			ext_cs_q <= 1'b0;
		end else begin
			addr_out_q <= int_addr_i;
			ext_addr_q <= addr_pin_i;
			dout_q <= dout_d;
			lane_oe_q <= {drive_data & ~narrow, drive_data};
			rdata_q <= rdata_d;
			ext_cs_q <= ext_hit;
		end
	end

	// pins follow bus ownership whatever the target, so internal cycles show outside
	assign addr_pin_oe_o = int_master_i;
	assign addr_pin_o = addr_out_q;
	assign ext_addr_seen_o = ext_addr_q;
	assign data_pin_o = dout_q;
	assign data_lane_oe_o = lane_oe_q;
	assign int_rdata_o = rdata_q;
	assign ext_chip_sel_o = ext_cs_q;
	assign ext_dtack_o = ext_cs_q;

	// one clock for every unit; the same net leaves the chip
	assign clock_output_pin_o = core_clk_i;

endmodule : scbp_sys_ctrl
`default_nettype wire

/* test/scbp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module scbp_chk
	import scbp_pkg::*;
(
	input wire logic core_clk_i, rst_i, int_master_i, addr_pin_oe_o,
	input wire logic watchdog_timeout_i, cs_addr_conflict_i, cs_write_protect_i,
	input wire logic bus_fault_line_oe_o, double_fault_i, halt_pin_oe_o,
	input wire logic core_reset_instr_i, core_reset_o, cp_reset_o, sib_reset_o,
	input wire logic sib_cfg_reset_o, reset_pin_oe_o, wide_bus_o, int_write_i,
	input wire logic bus_cycle_active_i, cs_range_hit_i, ext_chip_sel_o,
	input wire logic ext_dtack_o, bus_stop_o,
	input wire logic [1:0] data_lane_oe_o,
	input wire logic [DATA_W-1:0] data_pin_o, int_wdata_i,
	input wire logic [ADDR_HI:ADDR_LO] addr_pin_i, ext_addr_seen_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	addr_dir_a: assert property (addr_pin_oe_o == int_master_i)
		else $error("address direction wrong");
	fault_drive_a: assert property ((watchdog_timeout_i || cs_addr_conflict_i || cs_write_protect_i)
		|=> bus_fault_line_oe_o) else $error("bus fault not driven");
	halt_drive_a: assert property (double_fault_i && !core_reset_o |=> halt_pin_oe_o)
		else $error("halt not driven");
	instr_reset_a: assert property (core_reset_instr_i && !cp_reset_o && !core_reset_o
		|=> cp_reset_o && sib_reset_o && reset_pin_oe_o && !core_reset_o) else $error("instr reset wrong");
	total_all_a: assert property (core_reset_o |-> cp_reset_o && sib_reset_o && sib_cfg_reset_o)
		else $error("total reset partial");
	narrow_lane_a: assert property (!wide_bus_o && !$past(wide_bus_o)
		|-> !data_lane_oe_o[1] && data_pin_o[15:8] == 8'h00) else $error("upper lane used");
	wide_data_a: assert property (wide_bus_o && int_master_i && int_write_i && !core_reset_o
		|=> data_pin_o == $past(int_wdata_i)) else $error("word lanes wrong");
	ext_select_a: assert property (!int_master_i && bus_cycle_active_i && cs_range_hit_i
		|=> ext_chip_sel_o && ext_dtack_o) else $error("no chip select");
	halt_stop_a: assert property ($rose(bus_stop_o) |-> !$past(bus_cycle_active_i))
		else $error("stopped mid cycle");
	addr_seen_a: assert property (!$past(rst_i) |-> ext_addr_seen_o == $past(addr_pin_i))
		else $error("external address not seen");
	cover property (bus_stop_o);
	cover property (reset_pin_oe_o && cp_reset_o);
	cover property (ext_chip_sel_o);
endmodule : scbp_chk
bind scbp_sys_ctrl scbp_chk chk_i (.*);
`default_nettype wire

/* test/scbp_far.sv */
`timescale 1ns/1ps
`default_nettype none
module scbp_far (
	input wire logic ext_rst, ext_halt, ext_fault,
	input wire logic reset_pin_oe_o, halt_pin_oe_o, bus_fault_line_oe_o,
	input wire logic [1:0] data_lane_oe_o,
	input wire logic [15:0] data_pin_o, mem_data,
	output logic reset_pin_n_i, halt_pin_n_i, bus_fault_line_n_i,
	output logic [15:0] data_pin_i
);
	// pulled-up open-drain wires, any party pulling low wins
	assign reset_pin_n_i = !(reset_pin_oe_o || ext_rst);
	assign halt_pin_n_i = !(halt_pin_oe_o || ext_halt);
	assign bus_fault_line_n_i = !(bus_fault_line_oe_o || ext_fault);
	// memory answers only on lanes the device leaves free
	assign data_pin_i[15:8] = data_lane_oe_o[1] ? data_pin_o[15:8] : mem_data[15:8];
	assign data_pin_i[7:0] = data_lane_oe_o[0] ? data_pin_o[7:0] : mem_data[7:0];
endmodule : scbp_far
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import scbp_pkg::*;
	logic core_clk_i, rst_i, bus_width_strap_i, core_disable_strap_i, freeze_input_n_i, ext_rst, ext_halt, ext_fault;
	logic core_reset_instr_i, double_fault_i, watchdog_timeout_i, cs_addr_conflict_i, cs_write_protect_i;
	logic cs_range_hit_i, bus_cycle_active_i, int_master_i, int_a0_i, int_write_i;
	logic [7:0] freeze_select_i;
	logic [23:1] int_addr_i, addr_pin_i;
	logic [15:0] int_wdata_i, mem_data;
	wire clock_output_pin_o, reset_pin_n_o, reset_pin_oe_o, halt_pin_n_o, halt_pin_oe_o, addr_pin_oe_o;
	wire bus_fault_line_n_o, bus_fault_line_oe_o, core_reset_o, cp_reset_o, sib_reset_o, sib_cfg_reset_o;
	wire core_enable_o, wide_bus_o, bus_stop_o, bus_fault_o, ext_chip_sel_o, ext_dtack_o;
	wire reset_pin_n_i, halt_pin_n_i, bus_fault_line_n_i;
	wire [1:0] data_lane_oe_o;
	wire [7:0] freeze_unit_o;
	wire [15:0] int_rdata_o, data_pin_o, data_pin_i;
	wire [23:1] ext_addr_seen_o, addr_pin_o;
	int fails = 0;
	int tests_run = 0;
	// short reset-instruction pulse keeps the run brief
	scbp_sys_ctrl #(.FREEZE_N(8), .INSTR_RST_LEN(2)) uut (.*);
	scbp_far far (.*);
	always #4 core_clk_i = !core_clk_i;
	////////////////////////////////////////////////////////////////
	task chk(string n, logic [23:0] s, logic [23:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task w(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : w
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task t_total(logic b, logic d);
		@(posedge core_clk_i);
		ext_rst <= 1'h1;
		ext_halt <= 1'h1;
		bus_width_strap_i <= b;
		core_disable_strap_i <= d;
		w(12);
		chk("unit_rst", {core_reset_o, cp_reset_o, sib_reset_o, sib_cfg_reset_o}, 24'hF);
		@(posedge core_clk_i);
		ext_rst <= 1'h0;
		ext_halt <= 1'h0;
		w(5);
		chk("wide", wide_bus_o, b);
		chk("core_en", core_enable_o, !d);
		@(posedge core_clk_i);
		bus_width_strap_i <= !b;
		w(4);
		chk("strap_hold", wide_bus_o, b);
		$display("t_total done");
	endtask : t_total
	task t_bus(logic b);
		@(posedge core_clk_i);
		int_master_i <= 1'h1;
		int_write_i <= 1'h1;
		int_addr_i <= 23'h5A5A5A;
		int_wdata_i <= 16'h1234;
		w(2);
		chk("addr", {addr_pin_oe_o, addr_pin_o}, {1'h1, 23'h5A5A5A});
		chk("lane_oe", data_lane_oe_o, b ? 2'h3 : 2'h1);
		chk("dout", data_pin_o, b ? 16'h1234 : 16'h0012);
		@(posedge core_clk_i);
		int_master_i <= 1'h0;
		int_write_i <= 1'h0;
		mem_data <= 16'hABCD;
		addr_pin_i <= 23'h13579B;
		bus_cycle_active_i <= 1'h1;
		cs_range_hit_i <= 1'h1;
		w(2);
		chk("rdata", b ? int_rdata_o : {8'h00, int_rdata_o[15:8]}, b ? 16'hABCD : 16'h00CD);
		chk("aseen", {addr_pin_oe_o, ext_addr_seen_o}, 24'h13579B);
		chk("cs", {ext_chip_sel_o, ext_dtack_o}, 2'h3);
		@(posedge core_clk_i);
		bus_cycle_active_i <= 1'h0;
		cs_range_hit_i <= 1'h0;
		$display("t_bus done");
	endtask : t_bus
	task t_instr;
		@(posedge core_clk_i);
		core_reset_instr_i <= 1'h1;
		@(posedge core_clk_i);
		core_reset_instr_i <= 1'h0;
		#1;
		chk("instr", {cp_reset_o, sib_reset_o, reset_pin_oe_o, core_reset_o, sib_cfg_reset_o}, 5'h1C);
		w(4);
		chk("instr_end", {cp_reset_o, reset_pin_oe_o}, 2'h0);
		$display("t_instr done");
	endtask : t_instr
	task t_halt;
		@(posedge core_clk_i);
		double_fault_i <= 1'h1;
		w(2);
		chk("halt_oe", halt_pin_oe_o, 1'h1);
		@(posedge core_clk_i);
		double_fault_i <= 1'h0;
		bus_cycle_active_i <= 1'h1;
		ext_halt <= 1'h1;
		w(5);
		chk("stop_busy", bus_stop_o, 1'h0);
		@(posedge core_clk_i);
		bus_cycle_active_i <= 1'h0;
		w(2);
		chk("stop", bus_stop_o, 1'h1);
		@(posedge core_clk_i);
		ext_halt <= 1'h0;
		w(5);
		chk("go", bus_stop_o, 1'h0);
		$display("t_halt done");
	endtask : t_halt
	task t_fault;
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk_i);
			{watchdog_timeout_i, cs_addr_conflict_i, cs_write_protect_i} <= 3'h4 >> i;
			@(posedge core_clk_i);
			{watchdog_timeout_i, cs_addr_conflict_i, cs_write_protect_i} <= 3'h0;
			#1;
			chk("fault", {bus_fault_line_oe_o, bus_fault_o}, 2'h3);
			w(2);
			chk("fault_end", bus_fault_line_oe_o, 1'h0);
		end
		@(posedge core_clk_i);
		ext_fault <= 1'h1;
		w(3);
		chk("fault_ext", {bus_fault_line_oe_o, bus_fault_o}, 2'h1);
		@(posedge core_clk_i);
		ext_fault <= 1'h0;
		w(3);
		chk("fault_free", bus_fault_o, 1'h0);
		chk("od_low", {reset_pin_n_o, halt_pin_n_o, bus_fault_line_n_o}, 3'h0);
		$display("t_fault done");
	endtask : t_fault
	task t_freeze;
		@(posedge core_clk_i);
		freeze_select_i <= 8'h0F;
		freeze_input_n_i <= 1'h0;
		w(4);
		chk("freeze", freeze_unit_o, 8'h0F);
		@(posedge core_clk_i);
		freeze_input_n_i <= 1'h1;
		w(4);
		chk("thaw", freeze_unit_o, 8'h00);
		chk("clock_output_pin", clock_output_pin_o, 1'h1);
		$display("t_freeze done");
	endtask : t_freeze
	////////////////////////////////////////////////////////////////
	initial begin
		{core_clk_i, core_disable_strap_i, ext_rst, ext_halt, ext_fault, core_reset_instr_i, double_fault_i} = '0;
		{watchdog_timeout_i, cs_addr_conflict_i, cs_write_protect_i, cs_range_hit_i} = '0;
		{bus_cycle_active_i, int_master_i, int_a0_i, int_write_i, freeze_select_i} = '0;
		{int_addr_i, addr_pin_i, int_wdata_i, mem_data} = '0;
		{rst_i, bus_width_strap_i, freeze_input_n_i} = 3'h7;
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'h0;
		t_total(1'h0, 1'h1);
		t_bus(1'h0);
		t_total(1'h1, 1'h0);
		t_bus(1'h1);
		t_instr;
		t_halt;
		t_fault;
		t_freeze;
		test_done;
	end
	// whole run is about 130 cycles
	initial begin
		#50000;
		fails++;
		test_done;
	end
endmodule : testbench
`default_nettype wire
